// *** core/tsense_pkg.sv ***
// Package for the temperature sensor threshold control block.
// Holds register offsets, field positions, reset values and field layouts.
// Assumes a single register clock domain shared by all users of these names.
package tsense_pkg;

   // Register byte addresses
   localparam logic [15:0] SENSOR_CONTROL_OFFSET = 16'h11D4;
   localparam logic [15:0] SENSOR_STATUS_OFFSET  = 16'h11D8;
   localparam logic [15:0] SENSOR_ALARM_OFFSET   = 16'h11DC;

   // Field positions shared by the three registers
   localparam int TEMP_LO_BIT     = 0;
   localparam int MIN_LO_BIT      = 8;
   localparam int MAX_LO_BIT      = 16;
   localparam int FLAG_LO_BIT     = 24;
   localparam int RESERVED_BIT    = 30;
   localparam int UPDATED_BIT     = 31;
   localparam int THRESHOLD_COUNT = 3;
   localparam int FLAG_COUNT      = 6;

   // Values after reset
   localparam logic [7:0] THRESHOLD_RESET = 8'h00;
   localparam logic [5:0] ENABLE_RESET    = 6'h00;
   localparam logic       POWER_OFF_RESET = 1'h1;
   localparam logic [7:0] TEMP_RESET      = 8'h00;
   localparam logic [7:0] MINIMUM_RESET   = 8'hFF;
   localparam logic [7:0] MAXIMUM_RESET   = 8'h00;
   localparam logic [5:0] FLAG_RESET      = 6'h00;
   localparam logic       UPDATED_RESET   = 1'h0;

   // Synchroniser depth for the sensor inputs
   localparam int SYNC_STAGES = 2;

   // Control register layout, bit 31 down to bit 0
   typedef struct packed {
      logic       sensor_power_off;
      logic       reserved;
      logic [5:0] irq_enable;
      logic [7:0] high_threshold;
      logic [7:0] middle_threshold;
      logic [7:0] low_threshold;
   } control_t;

   // Alarm register layout, bit 31 down to bit 0
   typedef struct packed {
      logic       updated;
      logic       reserved;
      logic [5:0] flags;
      logic [7:0] recorded_maximum;
      logic [7:0] recorded_minimum;
      logic [7:0] low_byte;
   } alarm_t;

endpackage

// *** core/temp_sensor_threshold_ctrl.sv ***
// Temperature sensor control, status and alarm registers with threshold alarms.
// Assumes the analog sensor outside presents a sample value that is steady before it
// flips its sample toggle, and a register master that never needs wait states.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps

// Notes on behaviour
// RQ1: Low threshold, control bits 7:0, resets zero
// RQ2: Middle threshold, control bits 15:8, resets zero
// RQ3: High threshold, control bits 23:16, resets zero
// RQ4: Six interrupt enables in control bits 24-29
// RQ5: Enabled set flag raises both thermal status bits
// RQ6: Bit 31 powers sensor off; temperature reads zero
// RQ7: Status bits 7:0 show current temperature
// RQ8: Status shows recorded minimum and maximum
// RQ9: Status bits 24-29 mirror six alarm flags
// RQ10: Status bit 31 mirrors the updated flag
// RQ11: Flags set when sample below or above threshold
// RQ12: Reading alarm clears flags; writes load them
// RQ13: New sample sets updated, refreshes temperature, records
// RQ14: Minimum and maximum tracked since last write
// RQ15: Reserved bit 30 reads zero, ignores writes
module temp_sensor_threshold_ctrl #(
   parameter int ADDR_W = 16,
   parameter int TEMP_W = 8
) (
   // Clock and reset
   input  wire logic              CLOCK_IN,
   input  wire logic              ARST_N_IN,
   // Register port
   input  wire logic [ADDR_W-1:0] ADDR_IN,
   input  wire logic [31:0]       WDATA_IN,
   input  wire logic              WRITE_IN,
   input  wire logic              READ_IN,
   output logic      [31:0]       RDATA_OUT,
   // Analog sensor side
   input  wire logic              SENSOR_SAMPLE_TOGGLE_IN,
   input  wire logic [TEMP_W-1:0] SENSOR_VALUE_IN,
   output logic                   SENSOR_POWER_OFF_OUT,
   // Thermal status bits towards the upstream functions
   output logic                   BRIDGE_IRQ_STATUS_OUT,
   output logic                   NONTRANSPARENT_IRQ_STATUS_OUT
);

   // Register state
   tsense_pkg::control_t sensor_control_reg;
   logic [5:0]           flags;
   logic                 updated;
   logic [TEMP_W-1:0]    recorded_minimum;
   logic [TEMP_W-1:0]    recorded_maximum;
   logic [TEMP_W-1:0]    current_temp;

   // Synchronisers and sample detection
   logic [tsense_pkg::SYNC_STAGES-1:0] toggle_sync;
   logic                               toggle_seen;
   logic [TEMP_W-1:0]                  value_meta;
   logic [TEMP_W-1:0]                  value_sync;
   logic                               sample_event;
   logic                               new_sample;

   // Decoded accesses and derived values
   logic                 wr_control;
   logic                 wr_alarm;
   logic                 rd_alarm;
   logic [5:0]           hits;
   logic [5:0]           next_flags;
   logic                 next_updated;
   logic [TEMP_W-1:0]    shown_temp;
   logic [TEMP_W-1:0]    thresholds [tsense_pkg::THRESHOLD_COUNT];
   tsense_pkg::alarm_t   alarm_view;
   tsense_pkg::alarm_t   alarm_write;
   tsense_pkg::control_t control_write;
   logic [31:0]          next_rdata;
   logic                 alarm_active;

   // Address decode for the control and alarm registers
   assign wr_control    = WRITE_IN && (ADDR_IN == ADDR_W'(tsense_pkg::SENSOR_CONTROL_OFFSET));
   assign wr_alarm      = WRITE_IN && (ADDR_IN == ADDR_W'(tsense_pkg::SENSOR_ALARM_OFFSET));
   assign rd_alarm      = READ_IN && (ADDR_IN == ADDR_W'(tsense_pkg::SENSOR_ALARM_OFFSET));
   assign alarm_write   = tsense_pkg::alarm_t'(WDATA_IN);
   assign control_write = tsense_pkg::control_t'(WDATA_IN);

   // Sample toggle passes two flip-flops before the edge detector
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         toggle_sync <= '0;
         toggle_seen <= 1'b0;
      end else begin
         toggle_sync <= {toggle_sync[tsense_pkg::SYNC_STAGES-2:0], SENSOR_SAMPLE_TOGGLE_IN};
         toggle_seen <= toggle_sync[tsense_pkg::SYNC_STAGES-1];
      end
   end

   // Sample value passes two flip-flops as well
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         value_meta <= '0;
         value_sync <= '0;
      end else begin
         value_meta <= SENSOR_VALUE_IN;
         value_sync <= value_meta;
      end
   end

   // Either edge of the synchronised toggle marks one new sample
   assign sample_event = toggle_sync[tsense_pkg::SYNC_STAGES-1] ^ toggle_seen;
   // A powered-off sensor delivers no samples
   assign new_sample   = sample_event && !sensor_control_reg.sensor_power_off;

   // RQ1 RQ2 RQ3: thresholds in the order low, middle, high
   assign thresholds[0] = sensor_control_reg.low_threshold;
   assign thresholds[1] = sensor_control_reg.middle_threshold;
   assign thresholds[2] = sensor_control_reg.high_threshold;

   // RQ11: below and above compares per threshold
   generate
      for (genvar t = 0; t < tsense_pkg::THRESHOLD_COUNT; t++) begin : g_compare
         assign hits[2*t]   = new_sample && (value_sync < thresholds[t]);
         assign hits[2*t+1] = new_sample && (value_sync > thresholds[t]);
      end
   endgenerate

   // Control register, reserved bit forced to zero
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         sensor_control_reg.low_threshold    <= tsense_pkg::THRESHOLD_RESET;
         sensor_control_reg.middle_threshold <= tsense_pkg::THRESHOLD_RESET;
         sensor_control_reg.high_threshold   <= tsense_pkg::THRESHOLD_RESET;
         sensor_control_reg.irq_enable       <= tsense_pkg::ENABLE_RESET;
         sensor_control_reg.reserved         <= 1'b0;
         sensor_control_reg.sensor_power_off <= tsense_pkg::POWER_OFF_RESET;
      end else if (wr_control) begin
         // RQ1 RQ2 RQ3: software loads thresholds
         sensor_control_reg.low_threshold    <= control_write.low_threshold;
         sensor_control_reg.middle_threshold <= control_write.middle_threshold;
         sensor_control_reg.high_threshold   <= control_write.high_threshold;
         // RQ4: software loads the enables
         sensor_control_reg.irq_enable       <= control_write.irq_enable;
         // RQ15: reserved bit ignores writes
         sensor_control_reg.reserved         <= 1'b0;
         // RQ6: software sets power down
         sensor_control_reg.sensor_power_off <= control_write.sensor_power_off;
      end
   end

   // Next alarm flags: read clears, write loads, a hit always wins
   always_comb begin
      next_flags   = flags;
      next_updated = updated;
      // RQ12: read clears the flags
      if (rd_alarm) begin
         next_flags = tsense_pkg::FLAG_RESET;
      end
      // RQ12: write loads any value
      if (wr_alarm) begin
         next_flags = alarm_write.flags;
         if (alarm_write.updated) begin
            next_updated = 1'b0;
         end
      end
      // RQ11: hits set their flags
      next_flags = next_flags | hits;
      // RQ13: a sample sets updated
      if (new_sample) begin
         next_updated = 1'b1;
      end
   end

   // Alarm flags, sticky until read or written
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         flags <= tsense_pkg::FLAG_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   // Updated flag, cleared only by a write of one
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         updated <= tsense_pkg::UPDATED_RESET;
      end else begin
         updated <= next_updated;
      end
   end

   // Current temperature taken from each new sample
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         current_temp <= TEMP_W'(tsense_pkg::TEMP_RESET);
      end else if (new_sample) begin
         // RQ13: sample refreshes temperature
         current_temp <= value_sync;
      end
   end

   // Recorded minimum, a software write wins over a sample
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         recorded_minimum <= TEMP_W'(tsense_pkg::MINIMUM_RESET);
      end else if (wr_alarm) begin
         // RQ14: write restarts the minimum
         recorded_minimum <= alarm_write.recorded_minimum;
      end else if (new_sample && (value_sync < recorded_minimum)) begin
         // RQ14: lower sample is kept
         recorded_minimum <= value_sync;
      end
   end

   // Recorded maximum, a software write wins over a sample
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         recorded_maximum <= TEMP_W'(tsense_pkg::MAXIMUM_RESET);
      end else if (wr_alarm) begin
         // RQ14: write restarts the maximum
         recorded_maximum <= alarm_write.recorded_maximum;
      end else if (new_sample && (value_sync > recorded_maximum)) begin
         // RQ14: higher sample is kept
         recorded_maximum <= value_sync;
      end
   end

   // RQ6: temperature reads zero while off
   assign shown_temp = sensor_control_reg.sensor_power_off ? '0 : current_temp;

   // Alarm register as software sees it
   always_comb begin
      alarm_view                  = '0;
      alarm_view.recorded_minimum = recorded_minimum;
      alarm_view.recorded_maximum = recorded_maximum;
      alarm_view.flags            = flags;
      alarm_view.updated          = updated;
   end

   // Read multiplexer, unmapped addresses read zero
   always_comb begin
      next_rdata = '0;
      if (READ_IN) begin
         unique case (ADDR_IN)
            ADDR_W'(tsense_pkg::SENSOR_CONTROL_OFFSET): begin
               // RQ15: reserved bit reads zero
               next_rdata                          = sensor_control_reg;
               next_rdata[tsense_pkg::RESERVED_BIT] = 1'b0;
            end
            ADDR_W'(tsense_pkg::SENSOR_STATUS_OFFSET): begin
               // RQ7: current temperature field
               next_rdata[tsense_pkg::TEMP_LO_BIT +: TEMP_W] = shown_temp;
               // RQ8: recorded minimum and maximum
               next_rdata[tsense_pkg::MIN_LO_BIT +: TEMP_W]  = recorded_minimum;
               next_rdata[tsense_pkg::MAX_LO_BIT +: TEMP_W]  = recorded_maximum;
               // RQ9: mirrored alarm flags
               next_rdata[tsense_pkg::FLAG_LO_BIT +: tsense_pkg::FLAG_COUNT] = flags;
               // RQ10: mirrored updated flag
               next_rdata[tsense_pkg::UPDATED_BIT] = updated;
            end
            ADDR_W'(tsense_pkg::SENSOR_ALARM_OFFSET): begin
               next_rdata = alarm_view;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   // Read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         RDATA_OUT <= '0;
      end else begin
         RDATA_OUT <= next_rdata;
      end
   end

   // Power-down level towards the analog sensor
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         SENSOR_POWER_OFF_OUT <= tsense_pkg::POWER_OFF_RESET;
      end else begin
         // RQ6: drive sensor power down
         SENSOR_POWER_OFF_OUT <= sensor_control_reg.sensor_power_off;
      end
   end

   // RQ5: enable and flag both set
   assign alarm_active = |(sensor_control_reg.irq_enable & flags);

   // Thermal status bit towards the bridge functions
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         BRIDGE_IRQ_STATUS_OUT <= 1'b0;
      end else begin
         // RQ5: bridge status follows alarm
         BRIDGE_IRQ_STATUS_OUT <= alarm_active;
      end
   end

   // Thermal status bit towards the non-transparent functions
   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         NONTRANSPARENT_IRQ_STATUS_OUT <= 1'b0;
      end else begin
         // RQ5: non-transparent status follows alarm
         NONTRANSPARENT_IRQ_STATUS_OUT <= alarm_active;
      end
   end

endmodule

// *** bench/temp_sensor_threshold_ctrl_sva.sv ***
// Assertions on the temperature sensor block, seen from its top-level ports.
// Assumes one clock domain and a read answer in the cycle after the read strobe.
`timescale 1ns/1ps
module temp_sensor_threshold_ctrl_sva #(
   parameter int ADDR_W = 16,
   parameter int TEMP_W = 8
) (
   // Clock, reset and register port
   input wire logic              CLOCK_IN,
   input wire logic              ARST_N_IN,
   input wire logic [ADDR_W-1:0] ADDR_IN,
   input wire logic [31:0]       WDATA_IN,
   input wire logic              WRITE_IN,
   input wire logic              READ_IN,
   input wire logic [31:0]       RDATA_OUT,
   // Sensor side and thermal status
   input wire logic              SENSOR_SAMPLE_TOGGLE_IN,
   input wire logic [TEMP_W-1:0] SENSOR_VALUE_IN,
   input wire logic              SENSOR_POWER_OFF_OUT,
   input wire logic              BRIDGE_IRQ_STATUS_OUT,
   input wire logic              NONTRANSPARENT_IRQ_STATUS_OUT
);
   localparam logic [ADDR_W-1:0] CA = ADDR_W'(tsense_pkg::SENSOR_CONTROL_OFFSET);
   localparam logic [ADDR_W-1:0] SA = ADDR_W'(tsense_pkg::SENSOR_STATUS_OFFSET);
   localparam logic [ADDR_W-1:0] AA = ADDR_W'(tsense_pkg::SENSOR_ALARM_OFFSET);

   // One domain: shared clock and reset
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!ARST_N_IN);

   property p_rdata_idle; !READ_IN |=> RDATA_OUT == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
   property p_ctrl_rw; WRITE_IN && ADDR_IN == CA ##1 READ_IN && ADDR_IN == CA
      |=> RDATA_OUT == ($past(WDATA_IN, 2) & 32'hBFFFFFFF); endproperty
   a_ctrl_rw: assert property (p_ctrl_rw) else $error("control readback wrong");
   property p_pwr_follow; WRITE_IN && ADDR_IN == CA
      |=> ##1 SENSOR_POWER_OFF_OUT == $past(WDATA_IN[31], 2); endproperty
   a_pwr_follow: assert property (p_pwr_follow) else $error("power off output wrong");
   property p_pwr_read; READ_IN && ADDR_IN == CA |=> RDATA_OUT[31] == SENSOR_POWER_OFF_OUT;
   endproperty
   a_pwr_read: assert property (p_pwr_read) else $error("power bit mismatch");
   property p_temp_off; READ_IN && ADDR_IN == SA
      |=> SENSOR_POWER_OFF_OUT |-> RDATA_OUT[7:0] == 8'h00; endproperty
   a_temp_off: assert property (p_temp_off) else $error("temperature not zero");
   property p_irq_off; READ_IN && ADDR_IN == CA ##1 RDATA_OUT[29:24] == 6'h00
      |-> !BRIDGE_IRQ_STATUS_OUT; endproperty
   a_irq_off: assert property (p_irq_off) else $error("status bit with no enable");
   property p_irq_same; BRIDGE_IRQ_STATUS_OUT == NONTRANSPARENT_IRQ_STATUS_OUT; endproperty
   a_irq_same: assert property (p_irq_same) else $error("status outputs differ");
   property p_unmapped; READ_IN && ADDR_IN != CA && ADDR_IN != SA && ADDR_IN != AA
      |=> RDATA_OUT == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_resv; READ_IN && (ADDR_IN == SA || ADDR_IN == AA) |=> !RDATA_OUT[30];
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set");
endmodule

bind temp_sensor_threshold_ctrl temp_sensor_threshold_ctrl_sva #(
   .ADDR_W(ADDR_W), .TEMP_W(TEMP_W)) i_sva (
   .CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
   .WRITE_IN(WRITE_IN), .READ_IN(READ_IN), .RDATA_OUT(RDATA_OUT),
   .SENSOR_SAMPLE_TOGGLE_IN(SENSOR_SAMPLE_TOGGLE_IN), .SENSOR_VALUE_IN(SENSOR_VALUE_IN),
   .SENSOR_POWER_OFF_OUT(SENSOR_POWER_OFF_OUT), .BRIDGE_IRQ_STATUS_OUT(BRIDGE_IRQ_STATUS_OUT),
   .NONTRANSPARENT_IRQ_STATUS_OUT(NONTRANSPARENT_IRQ_STATUS_OUT));

// *** bench/tb_top.sv ***
// Self-checking bench for the temperature sensor block.
// Assumes the checker is bound in and the sensor toggle idles low at reset release.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
   localparam logic [15:0] CA = tsense_pkg::SENSOR_CONTROL_OFFSET;
   localparam logic [15:0] SA = tsense_pkg::SENSOR_STATUS_OFFSET;
   localparam logic [15:0] AA = tsense_pkg::SENSOR_ALARM_OFFSET;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h0;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic        tog = 1'b0;
   logic [7:0]  val = 8'h00;
   logic [31:0] rdata;
   logic        pwr;
   logic        irq_b;
   logic        irq_n;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cyc = 0;

   // 100 MHz clock
   always #5 clk = ~clk;

   temp_sensor_threshold_ctrl i_temp_sensor_threshold_ctrl (
      .CLOCK_IN(clk), .ARST_N_IN(arst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WRITE_IN(wr_s), .READ_IN(rd_s), .RDATA_OUT(rdata), .SENSOR_SAMPLE_TOGGLE_IN(tog),
      .SENSOR_VALUE_IN(val), .SENSOR_POWER_OFF_OUT(pwr), .BRIDGE_IRQ_STATUS_OUT(irq_b),
      .NONTRANSPARENT_IRQ_STATUS_OUT(irq_n));

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // One-cycle register write
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   // One-cycle read, data judged in the following cycle
   task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 `CHK(nm, e, rdata)
   endtask

   // Write then read back with no idle cycle between the strobes
   task automatic wr_rd(input logic [15:0] a, input logic [31:0] d, input logic [31:0] e,
                        input string nm);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 `CHK(nm, e, rdata)
   endtask

   // Value held steady around one toggle flip
   task automatic smp(input logic [7:0] v);
      @(posedge clk);
      val <= v;
      repeat (4) @(posedge clk);
      tog <= ~tog;
      repeat (6) @(posedge clk);
   endtask

   task automatic t_reset();
      rd(CA, 32'h80000000, "ctrl");
      rd(SA, 32'h0000FF00, "status");
      rd(AA, 32'h0000FF00, "alarm");
      `CHK("pwr", 1'b1, pwr)
   endtask

   task automatic t_ctrl();
      wr(CA, 32'hFFFFFFFF);
      rd(CA, 32'hBFFFFFFF, "ctrl all");
      wr_rd(CA, 32'h28604020, 32'h28604020, "ctrl thr");
      `CHK("pwr on", 1'b0, pwr)
      wr(SA, 32'hFFFFFFFF);
      rd(SA, 32'h0000FF00, "status ro");
      rd(16'h11E0, 32'h0, "unmapped");
   endtask

   task automatic t_sample();
      smp(8'h50);
      rd(SA, 32'h9A505050, "mid sample");
      `CHK("irq", 1'b1, irq_b)
      rd(AA, 32'h9A505000, "alarm read");
      rd(SA, 32'h80505050, "cleared");
      `CHK("irq clr", 1'b0, irq_n)
      smp(8'h10);
      rd(SA, 32'h95501010, "low sample");
      `CHK("irq mask", 1'b0, irq_b)
      smp(8'h70);
      rd(SA, 32'hBF701070, "high sample");
      `CHK("irq hi", 1'b1, irq_n)
      wr(AA, 32'h80000000);
      rd(AA, 32'h00000000, "alarm wr");
      smp(8'h30);
      rd(SA, 32'h96300030, "after wr");
      wr(AA, 32'h3F00FF00);
      rd(SA, 32'hBF00FF30, "flag load");
   endtask

   task automatic t_pwr();
      wr(CA, 32'hA8604020);
      rd(SA, 32'hBF00FF00, "off temp");
      wr(CA, 32'h80604020);
      rd(CA, 32'h80604020, "ctrl mask");
      `CHK("irq masked", 1'b0, irq_b)
      wr(AA, 32'h8000FF00);
      smp(8'h10);
      rd(SA, 32'h0000FF00, "off sample");
      `CHK("pwr off", 1'b1, pwr)
   endtask

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         test_done();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_ctrl();
      t_sample();
      t_pwr();
      test_done();
   end
endmodule
